// >>> shared/qdl_map.vh
// Field layout, reset values and counts of the quad converter serial front end
`ifndef QDL_MAP_VH
`define QDL_MAP_VH

// Serial word
`define QDL_WORD_BITS     24
`define QDL_CNT_BITS      5
`define QDL_CNT_FULL      5'h18

// Field positions inside the 24-bit word (bit 23 is spare, ignored)
`define QDL_PKG_MSB       22
`define QDL_PKG_LSB       18
`define QDL_CHAN_MSB      17
`define QDL_CHAN_LSB      16
`define QDL_DATA_MSB      15
`define QDL_DATA_LSB      0

// Widths
`define QDL_PKG_BITS      5
`define QDL_CHAN_BITS     2
`define QDL_DATA_BITS     16
`define QDL_CHANNELS      4

// Reset values
`define QDL_INPUT_RST     16'h0000
`define QDL_OUTPUT_RST    16'h0000
`define QDL_SHIFT_RST     24'h000000

`endif

// >>> verilog/qdl_sync.v
// Two-stage synchroniser for pins arriving from outside the system clock domain
module qdl_sync #(
	parameter           RST_VAL = 1'b0
) (
	input  wire         clk_sys_i,
	input  wire         reset_n_i,
	input  wire         pin_i,
	output wire         level_o
);

	reg                 meta_q;
	reg                 stable_q;

	// Only the second stage is visible outside
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q   <= RST_VAL;
			stable_q <= RST_VAL;
		end else begin
			meta_q   <= pin_i;
			stable_q <= meta_q;
		end
	end

	assign level_o = stable_q;

endmodule // qdl_sync

// >>> verilog/qdl_top.v
// Serial load, package match and output update logic of a quad converter
`include "qdl_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Shift data in on serial clock falling edges
// - Frame sync active low; bits only while low
// - Own package address from five hardwired pins
// - Bypass low: check package address each word
// - Bypass high: skip package check, decode channel
// - Load input high: output latches stay unchanged
// - Load input low: all channels update together
// - Clear low forces sense ground, asynchronously
// - After clear, sense ground until load low
// - Frame rising edge transfers 24-bit word
module qdl_top (
	input  wire         clk_sys_i,
	input  wire         reset_n_i,
	input  wire         serial_clk_i,
	input  wire         serial_data_i,
	input  wire         frame_sync_n_i,
	input  wire [4:0]   package_id_pins_i,
	input  wire         package_match_bypass_i,
	input  wire         load_outputs_n_i,
	input  wire         force_clear_n_i,
	output wire [63:0]  channel_output_o,
	output wire         sense_ground_level_o,
	output wire         word_taken_o,
	output wire         word_rejected_o
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	wire                sclk_s;
	wire                din_s;
	wire                frame_n_s;
	wire                bypass_s;
	wire                load_n_s;
	wire                clear_n_s;
	wire [4:0]          pkg_s;

	qdl_sync #(.RST_VAL(1'b0)) u_sync_sclk (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (serial_clk_i),
		.level_o   (sclk_s)
	);

	qdl_sync #(.RST_VAL(1'b0)) u_sync_din (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (serial_data_i),
		.level_o   (din_s)
	);

	qdl_sync #(.RST_VAL(1'b1)) u_sync_frame (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (frame_sync_n_i),
		.level_o   (frame_n_s)
	);

	qdl_sync #(.RST_VAL(1'b0)) u_sync_bypass (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (package_match_bypass_i),
		.level_o   (bypass_s)
	);

	qdl_sync #(.RST_VAL(1'b1)) u_sync_load (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (load_outputs_n_i),
		.level_o   (load_n_s)
	);

	qdl_sync #(.RST_VAL(1'b1)) u_sync_clear (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.pin_i     (force_clear_n_i),
		.level_o   (clear_n_s)
	);

	genvar              g;
	generate
		for (g = 0; g < `QDL_PKG_BITS; g = g + 1) begin : g_pkg
			// Straps are static but still pass two stages
			qdl_sync #(.RST_VAL(1'b0)) u_sync_pkg (
				.clk_sys_i (clk_sys_i),
				.reset_n_i (reset_n_i),
				.pin_i     (package_id_pins_i[g]),
				.level_o   (pkg_s[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Edge detection on synchronised levels

	reg                 sclk_d1_q;
	reg                 frame_d1_q;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_d1_q  <= 1'b0;
			frame_d1_q <= 1'b1;
		end else begin
			sclk_d1_q  <= sclk_s;
			frame_d1_q <= frame_n_s;
		end
	end

	function fell;
		input prev;
		input now;
		begin
			fell = prev & ~now;
		end
	endfunction

	wire                sclk_fall  = fell(sclk_d1_q, sclk_s);
	wire                frame_rise = fell(frame_n_s, frame_d1_q);
	wire                frame_on   = ~frame_n_s;

	////////////////////////////////////////////////////////////////////////////
	// Shift register and bit count

	reg  [23:0]         shift_q;
	reg  [4:0]          count_q;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_q <= `QDL_SHIFT_RST;
			count_q <= 5'h00;
		end else if (frame_rise) begin
			count_q <= 5'h00;
		end else if (frame_on && sclk_fall) begin
			shift_q <= {shift_q[22:0], din_s};
			if (count_q != `QDL_CNT_FULL) begin
				count_q <= count_q + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Word acceptance and input registers

	wire [4:0]          word_pkg  = shift_q[`QDL_PKG_MSB:`QDL_PKG_LSB];
	wire [1:0]          word_chan = shift_q[`QDL_CHAN_MSB:`QDL_CHAN_LSB];
	wire [15:0]         word_data = shift_q[`QDL_DATA_MSB:`QDL_DATA_LSB];
	wire                full_word = (count_q == `QDL_CNT_FULL);
	// Bypass skips only the package compare; channel is always decoded
	wire                pkg_ok    = bypass_s | (word_pkg == pkg_s);
	wire                accept    = frame_rise & full_word & pkg_ok;
	wire                reject    = frame_rise & ~accept;

	reg  [15:0]         input_q [0:3];
	reg                 taken_q;
	reg                 rejected_q;
	integer             i;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (i = 0; i < `QDL_CHANNELS; i = i + 1) begin
				input_q[i] <= `QDL_INPUT_RST;
			end
			taken_q    <= 1'b0;
			rejected_q <= 1'b0;
		end else begin
			taken_q    <= accept;
			rejected_q <= reject;
			if (accept) begin
				input_q[word_chan] <= word_data;
			end
		end
	end

	assign word_taken_o    = taken_q;
	assign word_rejected_o = rejected_q;

	////////////////////////////////////////////////////////////////////////////
	// Output latches and clear

	// The raw clear pin acts with no clock; a glitch on it clears the outputs
	wire                clr_rst_n = reset_n_i & force_clear_n_i;
	wire                load_now  = ~load_n_s & clear_n_s;

	reg  [63:0]         output_q;
	reg                 ground_q;

	always @(posedge clk_sys_i or negedge clr_rst_n) begin
		if (!clr_rst_n) begin
			output_q <= {`QDL_CHANNELS{`QDL_OUTPUT_RST}};
			ground_q <= 1'b1;
		end else if (load_now) begin
			// All four latches follow together while load is low
			output_q <= {input_q[3], input_q[2], input_q[1], input_q[0]};
			ground_q <= 1'b0;
		end
		// Load high leaves latches untouched
	end

	assign channel_output_o     = output_q;
	assign sense_ground_level_o = ground_q;

endmodule // qdl_top

// >>> sim/qdl_top_sva.sv
// Port-level assertions of the quad converter serial front end
module qdl_top_sva (
	input wire logic        clk_sys_i, reset_n_i, serial_clk_i, serial_data_i,
	input wire logic        frame_sync_n_i, package_match_bypass_i,
	input wire logic        load_outputs_n_i, force_clear_n_i,
	input wire logic [4:0]  package_id_pins_i,
	input wire logic [63:0] channel_output_o,
	input wire logic        sense_ground_level_o, word_taken_o, word_rejected_o
);
	timeunit 1ns / 1ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	wire ans = word_taken_o | word_rejected_o;
	// Load and clear cross two sync stages, so levels must be held a few cycles
	sequence s_load_low;
		(!load_outputs_n_i && force_clear_n_i)[*5];
	endsequence
	sequence s_load_high;
		(load_outputs_n_i && force_clear_n_i)[*4];
	endsequence
	a_clear_forces_ground: assert property (
		!force_clear_n_i |-> sense_ground_level_o && channel_output_o == 64'h0)
		else $error("outputs off ground during clear");
	a_hold_load_high: assert property (
		s_load_high |=> $stable(channel_output_o) || !force_clear_n_i)
		else $error("outputs moved with load high");
	a_load_updates: assert property (s_load_low |-> !sense_ground_level_o)
		else $error("load low did not update outputs");
	a_ground_until_load: assert property (
		sense_ground_level_o && load_outputs_n_i && $past(load_outputs_n_i)
		&& $past(load_outputs_n_i, 2) |=> sense_ground_level_o)
		else $error("ground left without load");
	a_ground_is_zero: assert property (
		sense_ground_level_o |-> channel_output_o == 64'h0)
		else $error("ground flag with nonzero outputs");
	a_taken_one_cycle: assert property (word_taken_o |=> !word_taken_o)
		else $error("taken pulse too long");
	a_answer_after_frame: assert property (ans |-> $past(frame_sync_n_i, 3))
		else $error("answer without frame end");
	a_idle_no_answer: assert property (frame_sync_n_i[*8] |=> !ans)
		else $error("answer while idle");
endmodule // qdl_top_sva
bind qdl_top qdl_top_sva qdl_top_sva_i (.*);

// >>> sim/qdl_host.sv
// Behavioural host that frames and shifts words into the converter
module qdl_host (
	input  wire logic clk_sys_i,
	output logic      serial_clk_o = 1'b1,
	output logic      serial_data_o = 1'b0,
	output logic      frame_sync_n_o = 1'b1
);
	timeunit 1ns / 1ps;
	// Serial clock idles high and stands still between frames
	task automatic send(input logic [23:0] w, input int n, input int half);
		frame_sync_n_o <= 1'b0;
		repeat (half) @(posedge clk_sys_i);
		for (int i = 23; i > 23 - n; i--) begin
			serial_data_o <= w[i];
			repeat (half) @(posedge clk_sys_i);
			serial_clk_o <= 1'b0;
			repeat (half) @(posedge clk_sys_i);
			serial_clk_o <= 1'b1;
		end
		repeat (half) @(posedge clk_sys_i);
		frame_sync_n_o <= 1'b1;
		// Released line flips so a stale bit never passes for a live one
		serial_data_o <= ~serial_data_o;
	endtask
endmodule // qdl_host

// >>> sim/testbench.sv
// Self-checking bench of the quad converter serial front end
module testbench;
	timeunit 1ns / 1ps;
	logic        clk_sys_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [4:0]  package_id_pins_i = 5'h15;
	logic        package_match_bypass_i = 1'b0;
	logic        load_outputs_n_i = 1'b1;
	logic        force_clear_n_i = 1'b1;
	wire         serial_clk_i, serial_data_i, frame_sync_n_i;
	wire         sense_ground_level_o, word_taken_o, word_rejected_o;
	wire  [63:0] channel_output_o;
	int          err_total = 0;
	int          checked = 0;
	int          cycles = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	qdl_top qdl_top_i (.*);
	qdl_host qdl_host_i (.clk_sys_i, .serial_clk_o(serial_clk_i),
		.serial_data_o(serial_data_i), .frame_sync_n_o(frame_sync_n_i));
	// One bit wider than the outputs so the ground flag and latches compare together
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic [23:0] w, input int n, half, input logic ok);
		logic tk, rj;
		tk = 1'b0;
		rj = 1'b0;
		@(posedge clk_sys_i);
		qdl_host_i.send(w, n, half);
		repeat (12) begin
			@(negedge clk_sys_i);
			tk |= word_taken_o;
			rj |= word_rejected_o;
		end
		chk({tk, rj}, {ok, ~ok});
	endtask
	task automatic load_all(input logic [63:0] exp);
		@(posedge clk_sys_i);
		load_outputs_n_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		load_outputs_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk(channel_output_o, exp);
	endtask
	task automatic sc_match;
		frame({1'b0, 5'h15, 2'h2, 16'hbeef}, 24, 4, 1'b1);
		chk(channel_output_o, 64'h0);
		load_all(64'h0000beef00000000);
	endtask
	task automatic sc_reject;
		frame({1'b0, 5'h0a, 2'h1, 16'h1234}, 24, 4, 1'b0);
		frame({1'b0, 5'h15, 2'h1, 16'h5678}, 23, 4, 1'b0);
		load_all(64'h0000beef00000000);
	endtask
	task automatic sc_bypass;
		package_match_bypass_i <= 1'b1;
		frame({1'b0, 5'h0a, 2'h0, 16'ha5a5}, 24, 4, 1'b1);
		chk(channel_output_o, 64'h0000beef00000000);
		@(posedge clk_sys_i);
		package_match_bypass_i <= 1'b0;
		load_all(64'h0000beef0000a5a5);
	endtask
	task automatic sc_clear;
		@(posedge clk_sys_i);
		force_clear_n_i <= 1'b0;
		load_outputs_n_i <= 1'b0;
		@(negedge clk_sys_i);
		chk({sense_ground_level_o, channel_output_o}, {1'b1, 64'h0});
		repeat (6) @(posedge clk_sys_i);
		load_outputs_n_i <= 1'b1;
		chk(channel_output_o, 64'h0);
		repeat (3) @(posedge clk_sys_i);
		force_clear_n_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		chk(sense_ground_level_o, 1'b1);
		load_all(64'h0000beef0000a5a5);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 8000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		sc_match();
		sc_reject();
		sc_bypass();
		sc_clear();
		tally_and_finish();
	end
endmodule // testbench
